// ### shared/dsm_map.svh
// timing and field constants for the debug serial memory port
`ifndef DSM_MAP_SVH
`define DSM_MAP_SVH
`define DSM_CMD_WIDTH      8
`define DSM_WORD_WIDTH     16
`define DSM_CMD_WRITE      8'h02
`define DSM_CMD_READ       8'h03
`define DSM_RESET_SCLK     2
`define DSM_SCLK_DIV       8
`define DSM_WRITE_BITS     40
`define DSM_READ_BITS      56
`endif

// ### shared/dsm_pkg.sv
// types shared by both ends of the debug serial memory port
package dsm_pkg;
    typedef enum logic [2:0] {
        DSM_IDLE = 3'b000,
        DSM_CMD  = 3'b001,
        DSM_ADDR = 3'b010,
        DSM_WDAT = 3'b011,
        DSM_RDAT = 3'b100,
        DSM_SKIP = 3'b101
    } dsm_state_t;
    typedef enum logic [1:0] {
        DSM_M_IDLE = 2'b00,
        DSM_M_RUN  = 2'b01,
        DSM_M_GAP  = 2'b10
    } dsm_mstate_t;
endpackage : dsm_pkg

// ### shared/dsm_link_if.sv
// serial link between debug master and device slave
`timescale 1ns/1ps
interface dsm_link_if;
    logic selectN;
    logic sclk;
    logic mosi;
    logic miso;
    modport master (output selectN, output sclk, output mosi, input miso);
    modport slave  (input selectN, input sclk, input mosi, output miso);
endinterface : dsm_link_if

// ### logic/dsm_sync.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module dsm_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             resetn,
    // data
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            stage1  <= '0;
            syncOut <= '0;
        end else begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule : dsm_sync

// ### logic/dsm_slave.sv
// device end: serial slave giving debug access to a 16-bit word space
`timescale 1ns/1ps
`include "dsm_map.svh"
module dsm_slave
    import dsm_pkg::*;
#(
    parameter int AW = 16,
    parameter int DW = 16
) (
    // system
    input  wire logic          clock,
    input  wire logic          resetn,
    // link
    dsm_link_if.slave          link,
    // memory side
    output logic               memWrite,
    output logic               memRead,
    output logic [AW-1:0]      memAddr,
    output logic [DW-1:0]      memWdata,
    input  wire logic [DW-1:0] memRdata,
    // processor state
    input  wire logic          cpuHalted
);
    logic [2:0]     pinSync;
    logic           selN;
    logic           sck;
    logic           sdi;
    logic           sckLast;
    logic           selLast;
    logic           rise;
    logic           fall;
    dsm_state_t     state;
    logic [4:0]     bitCount;
    logic [DW-1:0]  shiftIn;
    logic [DW-1:0]  shiftOut;
    logic [7:0]     command;
    logic [AW-1:0]  address;
    logic           isRead;
    logic [1:0]     highCount;
    logic           pendingRead;
    logic           misoReg;
    logic [DW-1:0]  nextShiftIn;
    logic           checkPhase;

    dsm_sync #(.WIDTH(3)) u_sync (
        .clock   (clock),
        .resetn  (resetn),
        .asyncIn ({link.selectN, link.sclk, link.mosi}),
        .syncOut (pinSync)
    );
    assign selN        = pinSync[2];
    assign sck         = pinSync[1];
    assign sdi         = pinSync[0];
    assign rise        = sck && !sckLast;
    assign fall        = !sck && sckLast;
    assign nextShiftIn = {shiftIn[DW-2:0], sdi};
    assign link.miso   = misoReg;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sckLast <= 1'b0;
            selLast <= 1'b1;
        end else begin
            sckLast <= sck;
            selLast <= selN;
        end
    end

    // counts serial clocks while deselected; the reset condition
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            highCount <= 2'h0;
        end else if (!selN) begin
            highCount <= 2'h0;
        end else if (rise && highCount != 2'(`DSM_RESET_SCLK)) begin
            highCount <= highCount + 2'h1;
        end
    end

    // transaction state; runs regardless of processor state
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state    <= DSM_IDLE;
            bitCount <= 5'h0;
            shiftIn  <= '0;
            command  <= 8'h00;
            address  <= '0;
            isRead   <= 1'b0;
        end else if (selN) begin
            // select rise ends the access
            if (highCount == 2'(`DSM_RESET_SCLK) || selLast == 1'b0) begin
                state <= DSM_IDLE;
            end
            bitCount <= 5'h0;
            isRead   <= 1'b0;
        end else if (rise) begin
            shiftIn  <= nextShiftIn;
            bitCount <= bitCount + 5'h1;
            case (state)
                DSM_IDLE, DSM_CMD: begin
                    state <= DSM_CMD;
                    if (bitCount == 5'(`DSM_CMD_WIDTH - 1)) begin
                        command  <= nextShiftIn[7:0];
                        bitCount <= 5'h0;
                        state    <= DSM_ADDR;
                    end
                end
                DSM_ADDR: begin
                    if (bitCount == 5'(`DSM_WORD_WIDTH - 1)) begin
                        address  <= nextShiftIn;
                        bitCount <= 5'h0;
                        if (command == `DSM_CMD_WRITE) begin
                            state <= DSM_WDAT;
                        end else if (command == `DSM_CMD_READ) begin
                            state  <= DSM_RDAT;
                            isRead <= 1'b1;
                        end else begin
                            state <= DSM_SKIP;
                        end
                    end
                end
                DSM_WDAT: begin
                    if (bitCount == 5'(`DSM_WORD_WIDTH - 1)) begin
                        bitCount <= 5'h0;
                    end
                end
                DSM_RDAT: begin
                    if (bitCount == 5'(`DSM_WORD_WIDTH - 1)) begin
                        bitCount <= 5'h0;
                    end
                end
                DSM_SKIP: begin
                    bitCount <= 5'h0;
                end
                default: begin
                    state <= DSM_IDLE;
                end
            endcase
        end else if (memWrite || (memRead && isRead)) begin
            address <= address + AW'(1);
        end
    end

    // high while the check word goes out, so the first fetched word is not
    // replaced before it has been shifted
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            checkPhase <= 1'b0;
        end else if (selN) begin
            checkPhase <= 1'b0;
        end else if (rise && state == DSM_ADDR && bitCount == 5'(`DSM_WORD_WIDTH - 1)) begin
            checkPhase <= 1'b1;
        end else if (rise && state == DSM_RDAT && bitCount == 5'(`DSM_WORD_WIDTH - 1)) begin
            checkPhase <= 1'b0;
        end
    end

    // memory strobes, one clock each
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            memWrite <= 1'b0;
            memRead  <= 1'b0;
            memAddr  <= '0;
            memWdata <= '0;
        end else begin
            memWrite <= !selN && rise && state == DSM_WDAT
                        && bitCount == 5'(`DSM_WORD_WIDTH - 1);
            memWdata <= nextShiftIn;
            memRead  <= !selN && rise && ((state == DSM_ADDR
                        && bitCount == 5'(`DSM_WORD_WIDTH - 1)
                        && command == `DSM_CMD_READ)
                        || (state == DSM_RDAT && bitCount == 5'h0 && !checkPhase));
            memAddr  <= (state == DSM_ADDR) ? nextShiftIn : address;
        end
    end

    // output shifter; check word then data words
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            shiftOut    <= '0;
            pendingRead <= 1'b0;
            misoReg     <= 1'b0;
        end else if (selN) begin
            misoReg     <= cpuHalted;
            pendingRead <= 1'b0;
        end else begin
            if (memRead) begin
                pendingRead <= 1'b1;
            end
            if (rise && state == DSM_ADDR && bitCount == 5'(`DSM_WORD_WIDTH - 1)) begin
                shiftOut <= {command, nextShiftIn[15:8]};
            end else if (fall && state == DSM_RDAT) begin
                if (bitCount == 5'h0 && pendingRead && !checkPhase) begin
                    misoReg     <= memRdata[DW-1];
                    shiftOut    <= {memRdata[DW-2:0], 1'b0};
                    pendingRead <= 1'b0;
                end else begin
                    misoReg  <= shiftOut[DW-1];
                    shiftOut <= {shiftOut[DW-2:0], 1'b0};
                end
            end
        end
    end
endmodule : dsm_slave

// ### logic/dsm_master.sv
// host end: serial master issuing debug reads and writes
`timescale 1ns/1ps
`include "dsm_map.svh"
module dsm_master
    import dsm_pkg::*;
#(
    parameter int DW = 16,
    parameter int AW = 16
) (
    // system
    input  wire logic          clock,
    input  wire logic          resetn,
    // link
    dsm_link_if.master         link,
    // request: one command and address; the word count is not used, every frame moves one word
    input  wire logic          reqValid,
    input  wire logic          reqRead,
    input  wire logic [AW-1:0] reqAddr,
    input  wire logic [7:0]    reqWords,
    output logic               reqReady,
    // write data per word, read data per word
    input  wire logic [DW-1:0] wrData,
    output logic               wrTake,
    output logic [DW-1:0]      rdData,
    output logic               rdValid,
    output logic               busy
);
    dsm_mstate_t  state;
    logic [7:0]   divCount;
    logic [5:0]   bitCount;
    logic [7:0]   wordsLeft;
    logic [39:0]  shiftOut;
    logic [DW-1:0] shiftIn;
    logic         isRead;
    logic         sclkReg;
    logic         selReg;
    logic         mosiReg;
    logic         misoSync;
    logic [5:0]   lastBit;
    logic [39:0]  frameWord;

    dsm_sync #(.WIDTH(1)) u_sync (
        .clock   (clock),
        .resetn  (resetn),
        .asyncIn (link.miso),
        .syncOut (misoSync)
    );
    assign link.selectN = selReg;
    assign link.sclk    = sclkReg;
    assign link.mosi    = mosiReg;
    // header plus one word; a read adds the check word
    assign lastBit      = isRead ? 6'(`DSM_READ_BITS) : 6'(`DSM_WRITE_BITS);
    assign frameWord    = {reqRead ? `DSM_CMD_READ : `DSM_CMD_WRITE, reqAddr, wrData};

    // divided serial clock; one half period is DSM_SCLK_DIV clocks
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state     <= DSM_M_IDLE;
            divCount  <= 8'h00;
            bitCount  <= 6'h00;
            wordsLeft <= 8'h00;
            shiftOut  <= '0;
            shiftIn   <= '0;
            isRead    <= 1'b0;
            sclkReg   <= 1'b0;
            selReg    <= 1'b1;
            mosiReg   <= 1'b0;
            reqReady  <= 1'b0;
            wrTake    <= 1'b0;
            rdData    <= '0;
            rdValid   <= 1'b0;
            busy      <= 1'b0;
        end else begin
            wrTake   <= 1'b0;
            rdValid  <= 1'b0;
            reqReady <= 1'b0;
            divCount <= divCount + 8'h01;
            case (state)
                DSM_M_IDLE: begin
                    // clock stopped with select high; the slave drops to idle
                    // on that select rise
                    selReg   <= 1'b1;
                    sclkReg  <= 1'b0;
                    busy     <= 1'b0;
                    divCount <= 8'h00;
                    if (reqValid && !reqReady) begin
                        reqReady  <= 1'b1;
                        busy      <= 1'b1;
                        isRead    <= reqRead;
                        wordsLeft <= (reqWords == 8'h00) ? 8'h01 : reqWords;
                        mosiReg   <= frameWord[39];
                        shiftOut  <= {frameWord[38:0], 1'b0};
                        selReg    <= 1'b0;
                        bitCount  <= 6'h00;
                        state     <= DSM_M_RUN;
                    end
                end
                DSM_M_RUN: begin
                    if (divCount == 8'(`DSM_SCLK_DIV - 1)) begin
                        divCount <= 8'h00;
                        if (!sclkReg) begin
                            sclkReg  <= 1'b1;
                            shiftIn  <= {shiftIn[DW-2:0], misoSync};
                            bitCount <= bitCount + 6'h01;
                        end else if (bitCount == lastBit) begin
                            // select rises only with the clock low again
                            sclkReg <= 1'b0;
                            selReg  <= 1'b1;
                            state   <= DSM_M_GAP;
                            if (isRead) begin
                                rdData  <= shiftIn;
                                rdValid <= 1'b1;
                            end else begin
                                wrTake <= 1'b1;
                            end
                        end else begin
                            // falling edge presents the next bit
                            sclkReg  <= 1'b0;
                            mosiReg  <= shiftOut[39];
                            shiftOut <= {shiftOut[38:0], 1'b0};
                        end
                    end
                end
                DSM_M_GAP: begin
                    selReg <= 1'b1;
                    if (divCount == 8'(`DSM_SCLK_DIV - 1)) begin
                        state <= DSM_M_IDLE;
                    end
                end
                default: begin
                    state <= DSM_M_IDLE;
                end
            endcase
        end
    end
endmodule : dsm_master

// ### sim/dsm_link_props.sv
// concurrent checks on the serial link between master and device ends
`timescale 1ns/1ps
module dsm_link_props (
    // system
    input wire logic clock,
    input wire logic resetn,
    // link
    input wire logic selectN,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso,
    // processor state
    input wire logic cpuHalted
);
    logic       sclkPrev;
    logic [6:0] riseCount;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sclkPrev <= 1'b0;
        end else begin
            sclkPrev <= sclk;
        end
    end
    // rises within one frame; cleared while deselected
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            riseCount <= 7'h00;
        end else if (selectN) begin
            riseCount <= 7'h00;
        end else if (sclk && !sclkPrev) begin
            riseCount <= riseCount + 7'h01;
        end
    end
    sequence s_high;
        sclk [*4];
    endsequence
    sequence s_low;
        !sclk [*4];
    endsequence
    property p_miso_idle;
        (selectN && $stable(cpuHalted)) [*8] |-> miso == cpuHalted;
    endproperty
    property p_miso_fall;
        !selectN && $past(!selectN, 8) && $changed(miso) |-> !sclk;
    endproperty
    property p_sclk_idle;
        selectN && $past(selectN) |-> !sclk;
    endproperty
    property p_mosi_hold;
        $rose(sclk) |-> $stable(mosi) ##1 $stable(mosi);
    endproperty
    property p_sclk_high;
        $rose(sclk) |-> s_high;
    endproperty
    property p_sclk_low;
        $fell(sclk) |-> s_low;
    endproperty
    property p_sel_hold;
        $fell(selectN) |-> (!selectN) [*8];
    endproperty
    // header plus one word, or header, check word and one word
    property p_frame_len;
        $rose(selectN) |-> riseCount == 7'h28 || riseCount == 7'h38;
    endproperty
    a_miso_idle: assert property (p_miso_idle) else $error("idle miso wrong");
    a_miso_fall: assert property (p_miso_fall) else $error("miso moved high");
    a_sclk_idle: assert property (p_sclk_idle) else $error("clock outside frame");
    a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved at rise");
    a_sclk_high: assert property (p_sclk_high) else $error("short high half");
    a_sclk_low: assert property (p_sclk_low) else $error("short low half");
    a_sel_hold: assert property (p_sel_hold) else $error("select glitch");
    a_frame_len: assert property (p_frame_len) else $error("frame length");
endmodule : dsm_link_props

// ### sim/test_debug_spi_slave_memory_access.sv
// bench: master and device joined, plus a second device driven by the bench
`timescale 1ns/1ps
module test_debug_spi_slave_memory_access;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        halt = 1'b0;
    logic        reqValid = 1'b0;
    logic        reqRead = 1'b0;
    logic [15:0] reqAddr = 16'h0000;
    logic [15:0] wrData = 16'h0000;
    logic [15:0] rdat1 = 16'h0000;
    logic [15:0] rdat2 = 16'h0000;
    logic        reqReady, rdValid, busy, wr1, rd1, wr2, rd2;
    logic [15:0] rdData, addr1, wdat1, addr2, wdat2, junk, ra, rw;
    logic [15:0] mem1 [0:65535];
    logic [15:0] mem2 [0:65535];
    logic [15:0] shadowB [0:65535];
    logic [31:0] wq1 [$];
    logic [31:0] wq2 [$];
    logic [15:0] rq [$];
    int          nMismatch = 0;
    int          checkCount = 0;
    dsm_link_if lk ();
    dsm_link_if lkB ();
    dsm_master dsm_master_inst (.clock(clock), .resetn(resetn), .link(lk.master),
        .reqValid(reqValid), .reqRead(reqRead), .reqAddr(reqAddr), .reqWords(8'h01),
        .reqReady(reqReady), .wrData(wrData), .wrTake(), .rdData(rdData), .rdValid(rdValid),
        .busy(busy));
    dsm_slave dsm_slave_inst (.clock(clock), .resetn(resetn), .link(lk.slave), .memWrite(wr1),
        .memRead(rd1), .memAddr(addr1), .memWdata(wdat1), .memRdata(rdat1), .cpuHalted(halt));
    dsm_slave dsm_slave_inst_b (.clock(clock), .resetn(resetn), .link(lkB.slave),
        .memWrite(wr2), .memRead(rd2), .memAddr(addr2), .memWdata(wdat2), .memRdata(rdat2),
        .cpuHalted(halt));
    dsm_link_props dsm_link_props_inst (.clock(clock), .resetn(resetn), .selectN(lk.selectN),
        .sclk(lk.sclk), .mosi(lk.mosi), .miso(lk.miso), .cpuHalted(halt));
    always #2.5 clock = ~clock;
    always @(posedge clock) begin
        if (rd1) rdat1 <= mem1[addr1];
        if (wr1) mem1[addr1] <= wdat1;
        if (rd2) rdat2 <= mem2[addr2];
        if (wr2) mem2[addr2] <= wdat2;
    end
    function automatic logic [15:0] pat(input logic [15:0] a);
        return a ^ 16'h5a5a;
    endfunction : pat
    task automatic testDone();
        if (nMismatch == 0 && checkCount > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : testDone
    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            nMismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp
    // sampled mid-cycle so the pulses have settled
    always @(negedge clock) begin
        if (wr1 === 1'b1) cmp("write one", wq1.size() ? wq1.pop_front() : 'x, {addr1, wdat1});
        if (wr2 === 1'b1) cmp("write two", wq2.size() ? wq2.pop_front() : 'x, {addr2, wdat2});
        if (rdValid === 1'b1) cmp("read one", rq.size() ? rq.pop_front() : 'x, rdData);
    end
    task automatic mreq(input logic rd, input logic [15:0] a, input logic [15:0] d);
        int k;
        int m;
        k = 0;
        m = 0;
        reqValid = 1'b1;
        reqRead = rd;
        reqAddr = a;
        wrData = d;
        if (rd) rq.push_back(d);
        else wq1.push_back({a, d});
        while (reqReady !== 1'b1 && k < 100) begin
            @(posedge clock);
            #1;
            k++;
        end
        // held one more edge so either reading of ready is met
        @(posedge clock);
        #1;
        reqValid = 1'b0;
        // a read frame is about 900 clocks, so the busy wait has its own bound
        while (busy !== 1'b0 && m < 3000) begin
            @(posedge clock);
            #1;
            m++;
        end
        if (k >= 100 || m >= 3000) begin
            cmp("handshake", 0, 1);
            testDone();
        end
    endtask : mreq
    task automatic shift(input logic [15:0] o, input int n, output logic [15:0] i);
        i = 16'h0000;
        for (int j = n - 1; j >= 0; j--) begin
            lkB.mosi = o[j];
            #40;
            lkB.sclk = 1'b1;
            i = {i[14:0], lkB.miso};
            #40;
            lkB.sclk = 1'b0;
        end
    endtask : shift
    task automatic frame(input logic [7:0] c, input logic [15:0] a, input int n, input int t);
        logic [15:0] got;
        logic [15:0] d;
        lkB.selectN = 1'b0;
        #40;
        shift({8'h00, c}, 8, got);
        shift(a, 16, got);
        if (c == 8'h03) shift(16'h0000, 16, got);
        if (c == 8'h03) cmp("check word", {c, a[15:8]}, got);
        for (int w = 0; w < n; w++) begin
            d = 16'($urandom());
            if (c == 8'h02) wq2.push_back({a + w[15:0], d});
            if (c == 8'h02) shadowB[a + w[15:0]] = d;
            shift(d, 16, got);
            if (c == 8'h03) cmp("read two", shadowB[a + w[15:0]], got);
        end
        shift(16'h0000, t, got);
        lkB.selectN = 1'b1;
        lkB.mosi = ~lkB.mosi;
        #200;
        cmp("idle miso", {31'h0000_0000, halt}, {31'h0000_0000, lkB.miso});
    endtask : frame
    initial begin
        #400000;
        cmp("run time", 0, 1);
        testDone();
    end
    initial begin
        lkB.selectN = 1'b1;
        lkB.sclk = 1'b0;
        lkB.mosi = 1'b0;
        void'($urandom(84));
        for (int i = 0; i < 65536; i++) begin
            mem1[i] = pat(i[15:0]);
            mem2[i] = pat(i[15:0]);
            shadowB[i] = pat(i[15:0]);
        end
        repeat (3) @(posedge clock);
        #1;
        resetn = 1'b1;
        for (int h = 0; h < 2; h++) begin
            halt = h[0];
            repeat (20) @(posedge clock);
            #1;
            ra = 16'($urandom());
            rw = 16'($urandom());
            mreq(1'b0, ra, rw);
            mreq(1'b1, ra, rw);
            mreq(1'b1, ~ra, pat(~ra));
            frame(8'h02, 16'hfffe, 3, 0);
            frame(8'h03, 16'hfffe, 3, 0);
        end
        frame(8'h05, 16'h0040, 2, 0);
        frame(8'h02, 16'h0040, 1, 7);
        lkB.selectN = 1'b0;
        shift(16'h0002, 8, junk);
        shift(16'h0123, 5, junk);
        lkB.selectN = 1'b1;
        shift(16'h0000, 2, junk);
        frame(8'h03, 16'h0040, 1, 0);
        repeat (50) @(posedge clock);
        cmp("queues left", 0, wq1.size() + wq2.size() + rq.size());
        testDone();
    end
endmodule : test_debug_spi_slave_memory_access
